// >>> hw/mrc_reset_ctrl.sv
// Purpose: combines pin, low-voltage, software and watchdog resets into one
//          synchronous system reset, and holds the bus pins during pin reset in mp mode
// Assumes: rst_i is the power-on reset; pins arrive asynchronously
// Notes:   registers reached over apb, zero wait states
`timescale 1ns/100ps
`default_nettype none

// Contract
// - pin low: ports reset, oscillator reset
// - pin rising: cpu/sfr reset, start at vector
// - pin reset keeps ram, power history flag
// - ram write during pin reset may corrupt
// - mp mode: strobes high, bus clock runs
// - hold ack follows hold; others float inputs
// - low voltage resets like pin reset; here no oscillator reset, and bus pins float in mp mode
// - soft reset bit resets cpu, sfr, ports
// - soft reset keeps mode, history, prescaler
// - watchdog underflow with select resets cpu, sfr, ports
// - watchdog reset keeps same bits
// - processor mode survives soft/watchdog reset
// - low-voltage release waits fixed delay
// - low-voltage reset only when enabled
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int unsigned LV_DELAY_CYC = LV_RELEASE_CYC,
  parameter int unsigned SOFT_CYC     = SOFT_HOLD_CYC
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // asynchronous pins and detector levels
  input  wire mrc_pkg::mrc_pins_in_s pins_i,
  // same-domain event from the watchdog
  input  wire logic                 wdog_underflow_i,
  // reset outputs
  output logic                      sys_reset_o,
  output logic                      port_reset_o,
  output logic                      osc_reset_o,
  output logic                      cpu_start_o,
  output logic [3:0]                reset_cause_o,
  // bus pins while held in reset
  output mrc_pkg::mrc_bus_pins_s    bus_pins_o,
  // preserved sfr state seen by the rest of the chip
  output logic [1:0]                proc_mode_o,
  output logic                      exempt_mode_bit_o,
  output logic                      power_history_flag_o,
  output logic [PRESC_W-1:0]        count_source_prescaler_o
);
  import mrc_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_PROC_MODE_REG0)    ||
                (a == OFF_WATCHDOG_CTRL_REG) ||
                (a == OFF_CLOCK_MODE_REG0)   ||
                (a == OFF_COUNT_PRESC_REG)   ||
                (a == OFF_VOLTAGE_CTRL_REG2) ||
                (a == OFF_RESET_STATUS_REG);
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input mrc_state_s s);
    logic [31:0] w;
    w = RD_ZERO;
    unique case (a)
      OFF_PROC_MODE_REG0: begin
        w[BIT_PROC_MODE_SEL_LO] = s.mode_lo;
        w[BIT_PROC_MODE_SEL_HI] = s.mode_hi;
        w[BIT_EXEMPT_MODE]      = s.exempt;
      end
      OFF_WATCHDOG_CTRL_REG: begin
        w[BIT_POWER_HISTORY] = s.hist;
      end
      OFF_CLOCK_MODE_REG0: begin
        w[BIT_WDOG_RESET_SEL] = s.wd_sel;
      end
      OFF_COUNT_PRESC_REG: begin
        w[PRESC_W-1:0] = s.presc;
      end
      OFF_VOLTAGE_CTRL_REG2: begin
        w[BIT_LV_RESET_ENABLE] = s.lv_en;
      end
      OFF_RESET_STATUS_REG: begin
        w[BIT_CAUSE_LSB +: 4]   = s.cause;
        w[BIT_SYS_IN_RESET]     = s.sys_rst;
      end
      default: begin
        w = RD_ZERO;
      end
    endcase
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  mrc_pins_in_s pin_s;

  mrc_sync #(
    .W ($bits(mrc_pins_in_s))
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (pins_i),
    .q_o       (pin_s)
  );

  // ----------------------------------------------------------------
  // release timer shared by low-voltage and soft resets
  // ----------------------------------------------------------------
  logic             dly_load;
  logic [CNT_W-1:0] dly_value;
  logic             dly_done;

  mrc_delay #(
    .W (CNT_W)
  ) u_delay (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .load_i    (dly_load),
    .value_i   (dly_value),
    .done_o    (dly_done)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mrc_state_s s_q;
  mrc_state_s s_d;

  logic pin_low;
  logic lv_active;
  logic apb_setup;
  logic apb_wr;
  logic soft_req;
  logic wdog_req;
  logic hw_entry;

  always_comb begin
    s_d       = s_q;
    dly_load  = 1'b0;
    dly_value = '0;

    pin_low   = ~pin_s.ext_reset_n;
    lv_active = s_q.lv_en & pin_s.lv_below;
    apb_setup = psel & ~penable;
    apb_wr    = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
    soft_req  = apb_wr & (paddr == OFF_PROC_MODE_REG0) &
                pwdata[BIT_SOFT_RESET_REQ];
    wdog_req  = s_q.wd_sel & wdog_underflow_i;

    // -------------------- sequencer --------------------
    // all sources end in one state machine so the system reset falls
    // on a single clock edge, whatever started it
    s_d.start = 1'b0;
    if (pin_low) begin
      s_d.st = ST_PIN;
    end else if (lv_active) begin
      s_d.st = ST_LV;
    end else begin
      unique case (s_q.st)
        ST_RUN: begin
          if (soft_req || wdog_req) begin
            s_d.st    = ST_SOFT;
            dly_load  = 1'b1;
            dly_value = CNT_W'(SOFT_CYC);
          end
        end
        ST_PIN: begin
          s_d.st = ST_REL;
        end
        ST_LV: begin
          if (pin_s.lv_recovered) begin
            s_d.st    = ST_LVWAIT;
            dly_load  = 1'b1;
            dly_value = CNT_W'(LV_DELAY_CYC);
          end
        end
        ST_LVWAIT: begin
          if (dly_done) begin
            s_d.st = ST_REL;
          end
        end
        ST_SOFT: begin
          if (dly_done) begin
            s_d.st = ST_REL;
          end
        end
        ST_REL: begin
          s_d.st    = ST_RUN;
          s_d.start = 1'b1;
        end
        default: begin
          s_d.st = ST_RUN;
        end
      endcase
    end

    // -------------------- reset outputs --------------------
    s_d.sys_rst  = (s_d.st != ST_RUN);
    s_d.port_rst = (s_d.st == ST_PIN) || (s_d.st == ST_LV) ||
                   (s_d.st == ST_LVWAIT) || (s_d.st == ST_SOFT);
    s_d.osc_rst  = (s_d.st == ST_PIN);

    // -------------------- cause capture --------------------
    hw_entry = ((s_d.st == ST_PIN) && (s_q.st != ST_PIN)) ||
               ((s_d.st == ST_LV) && (s_q.st != ST_LV) && (s_q.st != ST_LVWAIT));
    if ((s_d.st == ST_PIN) && (s_q.st != ST_PIN)) begin
      s_d.cause = 4'h1 << CAUSE_PIN;
    end else if (hw_entry) begin
      s_d.cause = 4'h1 << CAUSE_LV;
    end else if ((s_d.st == ST_SOFT) && (s_q.st == ST_RUN)) begin
      s_d.cause = soft_req ? (4'h1 << CAUSE_SOFT) : (4'h1 << CAUSE_WDOG);
    end

    // -------------------- sfr reset by kind --------------------
    // hardware resets reload the mode from the mode pin; the history
    // flag, ram and the enable of the detector itself are left alone
    if (s_d.st == ST_PIN || s_d.st == ST_LV) begin
      s_d.wd_sel  = 1'b0;
      s_d.presc   = PRESC_RST;
      s_d.mode_lo = pin_s.proc_mode_pin;
      s_d.mode_hi = 1'b0;
      s_d.exempt  = 1'b0;
    end else if (s_d.st == ST_SOFT) begin
      // mode bits, exempt bit, history flag and prescaler survive
      s_d.wd_sel  = 1'b0;
    end

    // -------------------- apb access --------------------
    // writes are dropped while the sfrs are held in reset
    if (apb_wr && !s_q.sys_rst && !pin_low) begin
      unique case (paddr)
        OFF_PROC_MODE_REG0: begin
          s_d.mode_lo = pwdata[BIT_PROC_MODE_SEL_LO];
          s_d.mode_hi = pwdata[BIT_PROC_MODE_SEL_HI];
          s_d.exempt  = pwdata[BIT_EXEMPT_MODE];
        end
        OFF_WATCHDOG_CTRL_REG: begin
          s_d.hist = pwdata[BIT_POWER_HISTORY];
        end
        OFF_CLOCK_MODE_REG0: begin
          s_d.wd_sel = pwdata[BIT_WDOG_RESET_SEL];
        end
        OFF_COUNT_PRESC_REG: begin
          s_d.presc = pwdata[PRESC_W-1:0];
        end
        OFF_VOLTAGE_CTRL_REG2: begin
          s_d.lv_en = pwdata[BIT_LV_RESET_ENABLE];
        end
        default: begin
          s_d.lv_en = s_d.lv_en;
        end
      endcase
    end

    // answer in the first access cycle
    s_d.pready  = apb_setup;
    s_d.pslverr = apb_setup & ~is_mapped(paddr);
    s_d.prdata  = (apb_setup && !pwrite) ? read_word(paddr, s_q) : RD_ZERO;

    // -------------------- bus pins --------------------
    // in microprocessor mode the strobes are driven inactive during pin
    // reset; elsewhere the bus pins float and are handed to the bus unit
    if ((s_d.st == ST_PIN) && pin_s.proc_mode_pin) begin
      s_d.bus.drive_n              = 1'b0;
      s_d.bus.wr                   = 1'b1;
      s_d.bus.rd                   = 1'b1;
      s_d.bus.high_byte_enable_out = 1'b1;
      s_d.bus.bclk                 = ~s_q.bus.bclk;
      s_d.bus.hold_ack_out         = pin_s.hold_req;
    end else begin
      s_d.bus.drive_n              = 1'b1;
      s_d.bus.wr                   = 1'b1;
      s_d.bus.rd                   = 1'b1;
      s_d.bus.high_byte_enable_out = 1'b1;
      s_d.bus.bclk                 = 1'b0;
      s_d.bus.hold_ack_out         = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // rst_i is the power-on reset: only it clears the history flag and the
  // detector enable; ram is never touched here, so a write cut by the pin
  // may leave a bad word
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q                          <= '0;
      s_q.st                       <= ST_PIN;
      s_q.sys_rst                  <= 1'b1;
      s_q.port_rst                 <= 1'b1;
      s_q.osc_rst                  <= 1'b1;
      s_q.presc                    <= PRESC_RST;
      s_q.bus.drive_n              <= 1'b1;
      s_q.bus.wr                   <= 1'b1;
      s_q.bus.rd                   <= 1'b1;
      s_q.bus.high_byte_enable_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                   = s_q.prdata;
  assign pready                   = s_q.pready;
  assign pslverr                  = s_q.pslverr;
  assign sys_reset_o              = s_q.sys_rst;
  assign port_reset_o             = s_q.port_rst;
  assign osc_reset_o              = s_q.osc_rst;
  assign cpu_start_o              = s_q.start;
  assign reset_cause_o            = s_q.cause;
  assign bus_pins_o               = s_q.bus;
  assign proc_mode_o              = {s_q.mode_hi, s_q.mode_lo};
  assign exempt_mode_bit_o        = s_q.exempt;
  assign power_history_flag_o     = s_q.hist;
  assign count_source_prescaler_o = s_q.presc;

endmodule
`default_nettype wire

// >>> hw/mrc_pkg.sv
// Purpose: shared constants, types and register map of the reset controller
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   offsets and field positions are used by the rtl and the bench
package mrc_pkg;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W                 = 8;
  localparam logic [7:0]  OFF_PROC_MODE_REG0     = 8'h00;
  localparam logic [7:0]  OFF_WATCHDOG_CTRL_REG  = 8'h04;
  localparam logic [7:0]  OFF_CLOCK_MODE_REG0    = 8'h08;
  localparam logic [7:0]  OFF_COUNT_PRESC_REG    = 8'h0c;
  localparam logic [7:0]  OFF_VOLTAGE_CTRL_REG2  = 8'h10;
  localparam logic [7:0]  OFF_RESET_STATUS_REG   = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_PROC_MODE_SEL_LO   = 0;
  localparam int unsigned BIT_PROC_MODE_SEL_HI   = 1;
  localparam int unsigned BIT_SOFT_RESET_REQ     = 3;
  localparam int unsigned BIT_EXEMPT_MODE        = 4;
  localparam int unsigned BIT_POWER_HISTORY      = 5;
  localparam int unsigned BIT_WDOG_RESET_SEL     = 6;
  localparam int unsigned BIT_LV_RESET_ENABLE    = 6;
  localparam int unsigned BIT_CAUSE_LSB          = 0;
  localparam int unsigned BIT_SYS_IN_RESET       = 4;
  localparam int unsigned PRESC_W                = 8;
  localparam logic [7:0]  PRESC_RST              = 8'h00;
  localparam logic [31:0] RD_ZERO                = 32'h0000_0000;

  // cause bits: which source started the last reset
  localparam int unsigned CAUSE_PIN              = 0;
  localparam int unsigned CAUSE_LV               = 1;
  localparam int unsigned CAUSE_SOFT             = 2;
  localparam int unsigned CAUSE_WDOG             = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ                = 250;
  localparam int unsigned LV_RELEASE_NS          = 1000;
  localparam int unsigned LV_RELEASE_CYC         = (LV_RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SOFT_HOLD_CYC          = 8;
  localparam int unsigned CNT_W                  = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_PIN    = 3'h1,
    ST_LV     = 3'h2,
    ST_LVWAIT = 3'h3,
    ST_SOFT   = 3'h4,
    ST_REL    = 3'h5
  } mrc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic high_byte_enable_out;
    logic bclk;
    logic hold_ack_out;
    logic drive_n;
  } mrc_bus_pins_s;

  typedef struct packed {
    logic ext_reset_n;
    logic lv_below;
    logic lv_recovered;
    logic proc_mode_pin;
    logic hold_req;
  } mrc_pins_in_s;

  typedef struct packed {
    mrc_state_e              st;
    logic                    wd_sel;
    logic                    lv_en;
    logic                    hist;
    logic                    mode_lo;
    logic                    mode_hi;
    logic                    exempt;
    logic [PRESC_W-1:0]      presc;
    logic [3:0]              cause;
    logic                    sys_rst;
    logic                    port_rst;
    logic                    osc_rst;
    logic                    start;
    mrc_bus_pins_s           bus;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } mrc_state_s;

endpackage

// >>> hw/mrc_sync.sv
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs are quasi-static levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module mrc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> hw/mrc_delay.sv
// Purpose: loadable down counter that reports expiry
// Assumes: load value of at least one
// Notes:   done is a level, high while the count sits at zero
`timescale 1ns/100ps
`default_nettype none
module mrc_delay #(
  parameter int unsigned W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              done_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// >>> test/mrc_board.sv
// Purpose: board reset circuit, oscillator and supply model
// Assumes: sys_clk_i doubles as the oscillator input
// Notes:   the rst_i period stands in for the supply settle time
`timescale 1ns/100ps
`default_nettype none
module mrc_board
  import mrc_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             hold_i,
  input  wire logic             lv_i,
  input  wire logic             mp_i,
  input  wire logic             hreq_i,
  output wire mrc_pkg::mrc_pins_in_s pins_o
);
  logic [4:0] osc_q = 5'h00;
  logic       pin_q = 1'b0;
  // pin starts low at power-on; release only after 20 oscillator cycles
  always @(posedge sys_clk_i) begin
    if (pin_q && hold_i) begin
      pin_q <= 1'b0;
      osc_q <= 5'h00;
    end else if (!pin_q) begin
      if (osc_q < 5'h14) osc_q <= osc_q + 5'h01;
      else if (!hold_i) pin_q <= 1'b1;
    end
  end
  // detector outputs are complementary, no hysteresis modelled
  assign pins_o = {pin_q, lv_i, !lv_i, mp_i, hreq_i};
endmodule
`default_nettype wire

// >>> test/mrc_reset_ctrl_chk.sv
// Purpose: port-level assertions on the reset controller
// Assumes: one clock domain, rst_i asynchronous
// Notes:   bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module mrc_chk
  import mrc_pkg::*;
#(
  parameter int unsigned LV_DELAY_CYC = LV_RELEASE_CYC
) (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire mrc_pkg::mrc_pins_in_s pins_i,
  input wire logic                  wdog_underflow_i,
  input wire logic                  sys_reset_o,
  input wire logic                  port_reset_o,
  input wire logic                  osc_reset_o,
  input wire logic                  cpu_start_o,
  input wire logic [3:0]            reset_cause_o,
  input wire mrc_pkg::mrc_bus_pins_s bus_pins_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // cycles in reset since the supply came back
  logic [15:0] lv_cnt_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) lv_cnt_q <= 16'h0000;
    else if (!sys_reset_o || !pins_i.lv_recovered) lv_cnt_q <= 16'h0000;
    else if (lv_cnt_q != 16'hffff) lv_cnt_q <= lv_cnt_q + 16'h0001;
  end
  a_pin_holds_all: assert property (!pins_i.ext_reset_n [*5] |-> port_reset_o && osc_reset_o && sys_reset_o)
    else $error("pin low but reset outputs not all high");
  a_start_on_fall: assert property (cpu_start_o |-> $fell(sys_reset_o) ##1 !cpu_start_o)
    else $error("start pulse not tied to reset release");
  a_strobes_high: assert property (osc_reset_o && !bus_pins_o.drive_n |->
    bus_pins_o.wr && bus_pins_o.rd && bus_pins_o.high_byte_enable_out)
    else $error("bus strobes low while held in reset");
  a_bclk_runs: assert property (!bus_pins_o.drive_n && $past(!bus_pins_o.drive_n) |->
    bus_pins_o.bclk != $past(bus_pins_o.bclk))
    else $error("bus clock stopped during reset");
  a_hold_follows: assert property ($stable(pins_i.hold_req) [*5] ##0 !bus_pins_o.drive_n |->
    bus_pins_o.hold_ack_out == pins_i.hold_req)
    else $error("hold acknowledge differs from hold request");
  a_port_in_sys: assert property (port_reset_o |-> sys_reset_o)
    else $error("port reset without system reset");
  a_wdog_cause: assert property ($rose(sys_reset_o) && $past(wdog_underflow_i) |-> reset_cause_o == 4'h8)
    else $error("watchdog reset with wrong cause");
  a_lv_delay: assert property ($fell(sys_reset_o) && reset_cause_o[CAUSE_LV] |->
    {16'h0000, lv_cnt_q} >= LV_DELAY_CYC)
    else $error("low voltage release too early");
  a_single_release: assert property ($fell(sys_reset_o) |-> !$past(port_reset_o))
    else $error("system reset left before port reset");
  c_start: cover property (cpu_start_o);
  c_wdog: cover property ($rose(sys_reset_o) && $past(wdog_underflow_i));
  c_lv: cover property ($fell(sys_reset_o) && reset_cause_o[CAUSE_LV]);
endmodule
bind mrc_reset_ctrl mrc_chk #(.LV_DELAY_CYC(LV_DELAY_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pins_i(pins_i), .wdog_underflow_i(wdog_underflow_i),
  .sys_reset_o(sys_reset_o), .port_reset_o(port_reset_o), .osc_reset_o(osc_reset_o),
  .cpu_start_o(cpu_start_o), .reset_cause_o(reset_cause_o), .bus_pins_o(bus_pins_o));
`default_nettype wire

// >>> test/mrc_reset_ctrl_tb.sv
// Purpose: self-checking bench for the reset controller
// Assumes: short delay parameters keep the run brief
// Notes:   pins come from the board model
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_tb;
  import mrc_pkg::*;
  localparam int unsigned LVD = 4;
  logic sys_clk_i = 1'b0, rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdog = 1'b0, pready, pslverr;
  logic hold = 1'b0, lv = 1'b0, hreq = 1'b0, mp = 1'b1, err, sys_r, port_r, osc_r, start, exempt, hist;
  logic [7:0] paddr = 8'h00, presc;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] cause;
  logic [1:0] pmode;
  mrc_pins_in_s pins;
  mrc_bus_pins_s bus;
  int n_mismatch = 0, comparisons = 0, n_start = 0, cyc = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  mrc_board u_board (.sys_clk_i(sys_clk_i), .hold_i(hold), .lv_i(lv), .mp_i(mp), .hreq_i(hreq), .pins_o(pins));
  mrc_reset_ctrl #(.LV_DELAY_CYC(LVD), .SOFT_CYC(2)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_i(pins), .wdog_underflow_i(wdog), .sys_reset_o(sys_r),
    .port_reset_o(port_r), .osc_reset_o(osc_r), .cpu_start_o(start), .reset_cause_o(cause),
    .bus_pins_o(bus), .proc_mode_o(pmode), .exempt_mode_bit_o(exempt), .power_history_flag_o(hist),
    .count_source_prescaler_o(presc));
  always @(posedge sys_clk_i) begin
    if (start === 1'b1) n_start++;
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // no wait-state count assumed: only the bench timeout ends a stuck access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (sys_r !== 1'b0 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 400) n_mismatch++;
  endtask
  task automatic t_power;
    rdc(OFF_PROC_MODE_REG0, 32'h1);
    // power-on starts in the pin state already, so no cause is latched
    rdc(OFF_RESET_STATUS_REG, 32'h0);
    rdc(8'h18, 32'h0);
    cmp(32'(err), 32'h1);
    cmp(n_start, 1);
    $display("test power done");
  endtask
  task automatic t_pin;
    int n;
    apb(1'b1, OFF_WATCHDOG_CTRL_REG, 32'h20);
    apb(1'b1, OFF_COUNT_PRESC_REG, 32'h5a);
    apb(1'b1, OFF_PROC_MODE_REG0, 32'h12);
    hold <= 1'b1; hreq <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    cmp({port_r, osc_r, sys_r}, 32'h7);
    cmp({bus.drive_n, bus.wr, bus.rd, bus.high_byte_enable_out, bus.hold_ack_out}, 32'h0f);
    n = bus.bclk;
    @(posedge sys_clk_i);
    cmp(32'(bus.bclk), 32'(!n));
    hreq <= 1'b0;
    apb(1'b1, OFF_COUNT_PRESC_REG, 32'h33);
    repeat (2) @(posedge sys_clk_i);
    cmp(32'(bus.hold_ack_out), 32'h0);
    hold <= 1'b0;
    wait_run(n);
    rdc(OFF_WATCHDOG_CTRL_REG, 32'h20);
    rdc(OFF_COUNT_PRESC_REG, 32'h0);
    rdc(OFF_PROC_MODE_REG0, 32'h1);
    rdc(OFF_RESET_STATUS_REG, 32'h1);
    cmp(n_start, 2);
    // single-chip mode: bus pins stay released, mode bit reloads from the pin
    mp <= 1'b0; hold <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    cmp({osc_r, bus.drive_n}, 32'h3);
    hold <= 1'b0;
    wait_run(n);
    rdc(OFF_PROC_MODE_REG0, 32'h0);
    mp <= 1'b1;
    $display("test pin done");
  endtask
  task automatic t_soft;
    int n;
    apb(1'b1, OFF_PROC_MODE_REG0, 32'h12);
    apb(1'b1, OFF_COUNT_PRESC_REG, 32'ha5);
    apb(1'b1, OFF_PROC_MODE_REG0, 32'h1a);
    cmp({sys_r, port_r}, 32'h3);
    wait_run(n);
    cmp({pmode, exempt, hist, presc}, {20'h0, 4'hb, 8'ha5});
    rdc(OFF_PROC_MODE_REG0, 32'h12);
    rdc(OFF_RESET_STATUS_REG, 32'h4);
    $display("test soft done");
  endtask
  task automatic t_wdog;
    int n;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFF_CLOCK_MODE_REG0, s ? 32'h40 : 32'h0);
      wdog <= 1'b1;
      @(posedge sys_clk_i);
      wdog <= 1'b0;
      @(posedge sys_clk_i);
      cmp(32'(sys_r), 32'(s));
    end
    wait_run(n);
    rdc(OFF_CLOCK_MODE_REG0, 32'h0);
    rdc(OFF_RESET_STATUS_REG, 32'h8);
    cmp({pmode, exempt, hist, presc}, {20'h0, 4'hb, 8'ha5});
    $display("test wdog done");
  endtask
  task automatic t_lv;
    int n;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFF_VOLTAGE_CTRL_REG2, s ? 32'h40 : 32'h0);
      lv <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      cmp({sys_r, port_r}, s ? 32'h3 : 32'h0);
      lv <= 1'b0;
      @(posedge sys_clk_i);
    end
    wait_run(n);
    cmp(32'(n >= LVD + 1), 32'h1);
    rdc(OFF_RESET_STATUS_REG, 32'h2);
    rdc(OFF_COUNT_PRESC_REG, 32'h0);
    rdc(OFF_VOLTAGE_CTRL_REG2, 32'h40);
    $display("test lv done");
  endtask
  task automatic finish_test;
    $display("counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    int n;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wait_run(n);
    t_power();
    t_pin();
    t_soft();
    t_wdog();
    t_lv();
    finish_test();
  end
endmodule
`default_nettype wire
